/* File: mlc_defines.svh */
// offsets, field positions, reset values, lead-angle knee and all-bytes enable of the loop configuration registers
//
// Contract
// RULE1 - first register bit 3: adaptive voltage enable
// RULE2 - first register bit 2: dead-time compensation enable
// RULE3 - second register at 48h, resets zero
// RULE4 - bits 31:28 spin-down speed threshold table
// RULE5 - bits 27:24 brake speed threshold, same table
// RULE6 - bits 23:19 brake current limit table
// RULE7 - bits 18:14 lead angle, doubled above 15
// RULE8 - reserved bits: zero, spare bit read/write
`ifndef MLC_DEFINES_SVH
`define MLC_DEFINES_SVH

`define MLC_LOOP1_OFS 8'h44
`define MLC_LOOP2_OFS 8'h48
`define MLC_LOOP1_RST 3'h0
`define MLC_LOOP2_RST 18'h00000
`define MLC_AVS_BIT 3
`define MLC_DTC_BIT 2
`define MLC_SPARE_BIT 1
`define MLC_SPIN_HI 31
`define MLC_SPIN_LO 28
`define MLC_BRKSPD_HI 27
`define MLC_BRKSPD_LO 24
`define MLC_BRKCUR_HI 23
`define MLC_BRKCUR_LO 19
`define MLC_LEAD_HI 18
`define MLC_LEAD_LO 14
`define MLC_LEAD_KNEE 6'h0F
`define MLC_ALL_BYTES 4'hF

`endif

/* File: mlc_pkg.sv */
// types shared by the loop configuration register bank
package mlc_pkg;
   typedef logic [7:0] mlc_addr_t;
   typedef logic [31:0] mlc_word_t;
   typedef logic [3:0] mlc_be_t;
   // thresholds in tenths of a percent of full scale
   typedef logic [9:0] mlc_permille_t;
   typedef logic [5:0] mlc_degree_t;
endpackage

/* File: mlc_regs.sv */
// loop configuration register bank with an Avalon-MM slave port
`timescale 1ns/1ps
`default_nettype none
`include "mlc_defines.svh"

module mlc_regs
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // avalon-mm slave
   input wire mlc_pkg::mlc_addr_t avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire mlc_pkg::mlc_word_t avs_writedata_i,
   input wire mlc_pkg::mlc_be_t avs_byteenable_i,
   output var mlc_pkg::mlc_word_t avs_readdata_o,
   output var logic avs_waitrequest_o,
   // raw fields
   output var logic adaptive_voltage_feature_enable_o,
   output var logic dead_time_comp_enable_o,
   output var logic [3:0] active_spindown_speed_limit_o,
   output var logic [3:0] brake_speed_limit_o,
   output var logic [4:0] brake_current_limit_o,
   output var logic [4:0] lead_angle_code_o,
   // decoded settings
   output var mlc_pkg::mlc_permille_t spindown_permille_o,
   output var mlc_pkg::mlc_permille_t brake_speed_permille_o,
   output var mlc_pkg::mlc_permille_t brake_current_permille_o,
   output var mlc_pkg::mlc_degree_t lead_angle_deg_o
);
   import mlc_pkg::*;

   // speed table shared by spin-down and brake speed thresholds
   function automatic mlc_permille_t speed_permille(input logic [3:0] code);
      mlc_permille_t v;
      v = 10'd0;
      unique case (code)
         4'h0: v = 10'd1000;
         4'h1: v = 10'd900;
         4'h2: v = 10'd800;
         4'h3: v = 10'd700;
         4'h4: v = 10'd600;
         4'h5: v = 10'd500;
         4'h6: v = 10'd450;
         4'h7: v = 10'd400;
         4'h8: v = 10'd350;
         4'h9: v = 10'd300;
         4'hA: v = 10'd250;
         4'hB: v = 10'd200;
         4'hC: v = 10'd150;
         4'hD: v = 10'd100;
         4'hE: v = 10'd50;
         4'hF: v = 10'd25;
      endcase
      return v;
   endfunction

   function automatic mlc_permille_t current_permille(input logic [4:0] code);
      mlc_permille_t v;
      v = 10'd0;
      unique case (code)
         5'h00: v = 10'd75;
         5'h01: v = 10'd80;
         5'h02: v = 10'd85;
         5'h03: v = 10'd90;
         5'h04: v = 10'd95;
         5'h05: v = 10'd100;
         5'h06: v = 10'd110;
         5'h07: v = 10'd120;
         5'h08: v = 10'd130;
         5'h09: v = 10'd140;
         5'h0A: v = 10'd150;
         5'h0B: v = 10'd160;
         5'h0C: v = 10'd170;
         5'h0D: v = 10'd180;
         5'h0E: v = 10'd200;
         5'h0F: v = 10'd225;
         5'h10: v = 10'd250;
         5'h11: v = 10'd275;
         5'h12: v = 10'd300;
         5'h13: v = 10'd350;
         5'h14: v = 10'd400;
         5'h15: v = 10'd450;
         5'h16: v = 10'd500;
         5'h17: v = 10'd550;
         5'h18: v = 10'd600;
         5'h19: v = 10'd700;
         5'h1A: v = 10'd750;
         5'h1B: v = 10'd800;
         5'h1C: v = 10'd850;
         5'h1D: v = 10'd900;
         5'h1E: v = 10'd950;
         5'h1F: v = 10'd1000;
      endcase
      return v;
   endfunction

   function automatic mlc_degree_t lead_degrees(input logic [4:0] code);
      mlc_degree_t v;
      v = {1'b0, code};
      if (v > `MLC_LEAD_KNEE)
      begin
         v = 6'({code, 1'b0}) - `MLC_LEAD_KNEE;
      end
      return v;
   endfunction

   function automatic mlc_word_t merge_bytes(input mlc_word_t old, input mlc_word_t wd,
                                             input mlc_be_t be);
      mlc_word_t v;
      v = old;
      for (int b = 0; b < 4; b++)
      begin
         if (be[b])
         begin
            v[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return v;
   endfunction

   logic [2:0] cfg1_q;
   logic [2:0] cfg1_d;
   logic [17:0] cfg2_q;
   logic [17:0] cfg2_d;
   logic waitreq_q;
   mlc_word_t rdata_q;

   // one wait cycle: the request is answered on the second edge it is seen
   wire req = avs_read_i | avs_write_i;
   wire ack = req & ~waitreq_q;
   wire hit1 = (avs_address_i == `MLC_LOOP1_OFS);
   wire hit2 = (avs_address_i == `MLC_LOOP2_OFS); // RULE3
   // reserved bits below the lead angle always read zero
   wire mlc_word_t view1 = {28'h0000000, cfg1_q, 1'b0};
   wire mlc_word_t view2 = {cfg2_q, 14'h0000}; // RULE8
   wire mlc_word_t view = hit1 ? view1 : (hit2 ? view2 : 32'h00000000);
   wire mlc_word_t merged1 = merge_bytes(view1, avs_writedata_i, avs_byteenable_i);
   wire mlc_word_t merged2 = merge_bytes(view2, avs_writedata_i, avs_byteenable_i);
   wire wr_commit = ack & avs_write_i;

   assign cfg1_d = (wr_commit & hit1) ? merged1[`MLC_AVS_BIT:`MLC_SPARE_BIT] : cfg1_q; // RULE1 RULE2
   assign cfg2_d = (wr_commit & hit2) ? merged2[`MLC_SPIN_HI:`MLC_LEAD_LO] : cfg2_q; // RULE4

   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         cfg1_q <= `MLC_LOOP1_RST; // RULE1 RULE2 RULE8
         cfg2_q <= `MLC_LOOP2_RST; // RULE3
         waitreq_q <= 1'b1;
         rdata_q <= 32'h00000000;
      end
      else
      begin
         cfg1_q <= cfg1_d;
         cfg2_q <= cfg2_d;
         waitreq_q <= ~(req & waitreq_q);
         rdata_q <= (req & waitreq_q) ? view : rdata_q;
      end
   end

   // decoded outputs follow the next register value so they change on the write edge
   always_ff @(posedge clock_i)
   begin
      if (!rst_b_i)
      begin
         spindown_permille_o <= 10'd1000;
         brake_speed_permille_o <= 10'd1000;
         brake_current_permille_o <= 10'd75;
         lead_angle_deg_o <= 6'h00;
      end
      else
      begin
         spindown_permille_o <= speed_permille(cfg2_d[17:14]); // RULE4
         brake_speed_permille_o <= speed_permille(cfg2_d[13:10]); // RULE5
         brake_current_permille_o <= current_permille(cfg2_d[9:5]); // RULE6
         lead_angle_deg_o <= lead_degrees(cfg2_d[4:0]); // RULE7
      end
   end

   assign avs_readdata_o = rdata_q;
   assign avs_waitrequest_o = waitreq_q;
   assign adaptive_voltage_feature_enable_o = cfg1_q[2]; // RULE1
   assign dead_time_comp_enable_o = cfg1_q[1]; // RULE2
   assign active_spindown_speed_limit_o = cfg2_q[17:14]; // RULE4
   assign brake_speed_limit_o = cfg2_q[13:10]; // RULE5
   assign brake_current_limit_o = cfg2_q[9:5]; // RULE6
   assign lead_angle_code_o = cfg2_q[4:0]; // RULE7

   sequence s_l2_full_write;
      !avs_waitrequest_o && avs_write_i && hit2 && avs_byteenable_i == `MLC_ALL_BYTES;
   endsequence

   a_wait_answer: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      req && avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("request not answered after one wait cycle");
   a_ack_single: assert property (@(posedge clock_i) disable iff (!rst_b_i)
      !avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low for more than one cycle");
   a_reset_zero: assert property (@(posedge clock_i) // RULE3
      !rst_b_i |=> cfg2_q == 18'h00000 && cfg1_q == 3'h0 && lead_angle_deg_o == 6'h00)
      else $error("registers not zero after reset");
   a_l2_write_back: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE4
      s_l2_full_write |=> active_spindown_speed_limit_o == $past(avs_writedata_i[31:28])
         && brake_current_limit_o == $past(avs_writedata_i[23:19]))
      else $error("second register write not stored");
   a_avs_enable: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE1
      wr_commit && hit1 && avs_byteenable_i[0] |=> adaptive_voltage_feature_enable_o
         == $past(avs_writedata_i[3]) && dead_time_comp_enable_o == $past(avs_writedata_i[2]))
      else $error("first register enables not written");
   a_reserved_zero: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE8
      !avs_waitrequest_o && avs_read_i && hit2 |-> avs_readdata_o[13:0] == 14'h0000)
      else $error("reserved bits read nonzero");
   a_l1_readback: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE8
      !avs_waitrequest_o && avs_read_i && hit1 |-> avs_readdata_o[31:4] == 28'h0000000
         && avs_readdata_o[0] == 1'b0)
      else $error("first register upper bits nonzero");
   a_spin_table: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE4
      (s_l2_full_write and (avs_writedata_i[31:28] == 4'hF)) |=> spindown_permille_o == 10'd25)
      else $error("spin-down code F not 2.5 percent");
   a_brake_speed: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE5
      (s_l2_full_write and (avs_writedata_i[27:24] == 4'h6)) |=>
         brake_speed_permille_o == 10'd450)
      else $error("brake speed code 6 not 45 percent");
   a_brake_current: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE6
      (s_l2_full_write and (avs_writedata_i[23:19] == 5'h0F)) |=>
         brake_current_permille_o == 10'd225)
      else $error("brake current code F not 22.5 percent");
   a_lead_angle: assert property (@(posedge clock_i) disable iff (!rst_b_i) // RULE7
      (s_l2_full_write and (avs_writedata_i[18:14] == 5'h1F)) |=> lead_angle_deg_o == 6'd47)
      else $error("lead angle code 31 not 47 degrees");
endmodule
`default_nettype wire

/* File: tb_top.sv */
// self-checking testbench for the loop configuration register bank
`timescale 1ns/1ps
`default_nettype none
`include "mlc_defines.svh"
module tb_top;
   import mlc_pkg::*;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   mlc_addr_t addr = 8'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   mlc_word_t wdata = 32'h0;
   mlc_be_t be = 4'h0;
   mlc_word_t rdata, got;
   mlc_word_t m1 = 32'h0;
   mlc_word_t m2 = 32'h0;
   logic wait_req, avf, dtc;
   logic [3:0] spin, bspd;
   logic [4:0] bcur, lead, c;
   mlc_permille_t spin_pm, bspd_pm, bcur_pm;
   mlc_degree_t lead_deg;
   logic [31:0] seed = 32'h0000000C;
   int n_mismatch = 0;
   int compares = 0;
   always #50 clock_i = ~clock_i;
   mlc_regs u_dut (.clock_i(clock_i), .rst_b_i(rst_b_i), .avs_address_i(addr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
      .avs_readdata_o(rdata), .avs_waitrequest_o(wait_req),
      .adaptive_voltage_feature_enable_o(avf), .dead_time_comp_enable_o(dtc),
      .active_spindown_speed_limit_o(spin), .brake_speed_limit_o(bspd),
      .brake_current_limit_o(bcur), .lead_angle_code_o(lead), .spindown_permille_o(spin_pm),
      .brake_speed_permille_o(bspd_pm), .brake_current_permille_o(bcur_pm),
      .lead_angle_deg_o(lead_deg));
   function automatic logic [31:0] xorshift(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction
   function automatic mlc_permille_t spd(input logic [3:0] k);
      int t[16] = '{1000, 900, 800, 700, 600, 500, 450, 400, 350, 300, 250, 200, 150, 100, 50, 25};
      return mlc_permille_t'(t[k]);
   endfunction
   function automatic mlc_permille_t cur(input logic [4:0] k);
      int t[32] = '{75, 80, 85, 90, 95, 100, 110, 120, 130, 140, 150, 160, 170, 180, 200, 225,
         250, 275, 300, 350, 400, 450, 500, 550, 600, 700, 750, 800, 850, 900, 950, 1000};
      return mlc_permille_t'(t[k]);
   endfunction
   function automatic logic [9:0] deg(input logic [4:0] k);
      // the knee value itself stays one degree per step
      return (k <= 5'h0F) ? 10'(k) : 10'(2 * k - 15);
   endfunction
   task automatic cmp_word(input mlc_word_t exp, input mlc_word_t act);
      compares++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: word expected %h got %h", $time, exp, act);
      end
   endtask
   task automatic cmp_field(input logic [15:0] exp, input logic [15:0] act);
      compares++;
      if (act !== exp)
      begin
         n_mismatch++;
         $display("Error at %0t: field expected %h got %h", $time, exp, act);
      end
   endtask
   task automatic bus(input logic w, input mlc_addr_t a, input mlc_word_t d, input mlc_be_t b);
      int n;
      @(posedge clock_i);
      addr <= a;
      wdata <= d;
      be <= b;
      wr <= w;
      rd <= !w;
      n = 0;
      do
      begin
         @(posedge clock_i);
         n++;
      end
      while (wait_req !== 1'b0 && n < 20);
      if (wait_req !== 1'b0)
         n_mismatch++;
      got = rdata;
      rd <= 1'b0;
      wr <= 1'b0;
      for (int k = 0; k < 4; k++)
      begin
         if (w && b[k] && a == `MLC_LOOP1_OFS)
            m1[8*k+:8] = d[8*k+:8];
         if (w && b[k] && a == `MLC_LOOP2_OFS)
            m2[8*k+:8] = d[8*k+:8];
      end
      // reserved places never hold a one
      m1 = m1 & 32'h0000000E;
      m2 = m2 & 32'hFFFFC000;
   endtask
   task automatic check_reg(input mlc_addr_t a, input mlc_word_t exp);
      seed = xorshift(seed);
      bus(1'b0, a, seed, seed[3:0]);
      cmp_word(exp, got);
   endtask
   task automatic check_outs;
      @(posedge clock_i);
      cmp_field({15'h0000, m1[3]}, {15'h0000, avf});
      cmp_field({15'h0000, m1[2]}, {15'h0000, dtc});
      cmp_field({2'h0, m2[31:28], spd(m2[31:28])}, {2'h0, spin, spin_pm});
      cmp_field({2'h0, m2[27:24], spd(m2[27:24])}, {2'h0, bspd, bspd_pm});
      cmp_field({1'h0, m2[23:19], cur(m2[23:19])}, {1'h0, bcur, bcur_pm});
      cmp_field({1'h0, m2[18:14], deg(m2[18:14])}, {1'h0, lead, 4'h0, lead_deg});
   endtask
   task automatic tally_and_finish;
      $display("compares %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      check_outs;
      check_reg(`MLC_LOOP1_OFS, 32'h0);
      check_reg(`MLC_LOOP2_OFS, 32'h0);
      $display("test reset done");
      for (int i = 0; i < 32; i++)
      begin
         c = 5'(i);
         seed = xorshift(seed);
         bus(1'b1, `MLC_LOOP2_OFS, {c[3:0], ~c[3:0], c, ~c, seed[13:0]}, `MLC_ALL_BYTES);
         check_outs;
         check_reg(`MLC_LOOP2_OFS, m2);
      end
      $display("test field codes done");
      for (int i = 0; i < 6; i++)
      begin
         seed = xorshift(seed);
         bus(1'b1, `MLC_LOOP1_OFS, (i < 2) ? {32{i[0]}} : seed, `MLC_ALL_BYTES);
         check_outs;
         check_reg(`MLC_LOOP1_OFS, m1);
      end
      $display("test first register done");
      for (int i = 0; i < 6; i++)
      begin
         seed = xorshift(seed);
         bus(1'b1, `MLC_LOOP2_OFS, seed, seed[31:28]);
         check_reg(`MLC_LOOP2_OFS, m2);
      end
      $display("test byte lanes done");
      bus(1'b1, 8'h4C, 32'hFFFFFFFF, `MLC_ALL_BYTES);
      check_reg(8'h4C, 32'h0);
      check_reg(`MLC_LOOP2_OFS, m2);
      check_reg(`MLC_LOOP1_OFS, m1);
      $display("test unmapped done");
      @(posedge clock_i);
      rst_b_i <= 1'b0;
      repeat (2) @(posedge clock_i);
      rst_b_i <= 1'b1;
      m1 = 32'h0;
      m2 = 32'h0;
      check_outs;
      check_reg(`MLC_LOOP2_OFS, 32'h0);
      $display("test second reset done");
      tally_and_finish;
   end
   initial
   begin
      repeat (3000) @(posedge clock_i);
      n_mismatch++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
